// file: logic/cpuamd_decoder.sv
// Addressing mode decoder: takes an opcode and its operand bytes from
// the fetch stream, fetches page-zero pointers, forms the address.
// Assumes the fetch stream, index and PC share SYS_CLK; the data bus
// answers a read request with one MEM_RVALID pulse.
//
// Behaviour
// RQ1 - Seventeen addressing modes in seven families are decoded.
// RQ2 - Long forms form addresses over the whole 64 Kbyte space.
// RQ3 - Short forms keep the address in page zero, 0000h to 00FFh; M_IDX_S and M_IIX_S add the index and reach 01FE.
// RQ4 - Read-modify-write and bit operations refuse long forms.
// RQ5 - Inherent has no operand byte; immediate has one, the value.
// RQ6 - Indexed without offset uses the index alone, no operand byte.
// RQ7 - Short indexed adds a byte offset up to 01FE; long adds two.
// RQ8 - Indirect forms read a page-zero byte or word pointer, 2 bytes.
// RQ9 - Relative targets lie within +/-127 of PC, 1 or 2 bytes.
// RQ10 - Bit forms target page zero with 1, 2 or 3 operand bytes.
// RQ11 - Mode, length and pointer need appear before operand fetch.
`timescale 1ns/100ps
`default_nettype none
module cpuamd_decoder
	import cpuamd_pkg::*;
(
	input  wire logic           SYS_CLK,
	input  wire logic           SYS_RST,
	input  wire logic           BYTE_VALID,
	input  wire logic [7:0]     BYTE_DATA,
	output var  logic           BYTE_TAKE,
	input  wire logic [7:0]     INDEX_X,
	input  wire logic [15:0]    PC_NEXT,
	output var  logic           MEM_RREQ,
	output var  logic [15:0]    MEM_RADDR,
	input  wire logic           MEM_RVALID,
	input  wire logic [7:0]     MEM_RDATA,
	output var  cpuamd_info_s   DEC_INFO,
	output var  logic           DEC_INFO_VALID,
	output var  logic           DEC_ILLEGAL,
	output var  cpuamd_result_s DEC_RESULT,
	output var  logic           DEC_DONE
);

	cpuamd_state_e state_q, state_d;
	cpuamd_info_s  info_d;
	logic [1:0]    cnt_q;
	logic [7:0]    opb_q [3];
	logic [7:0]    plo_q, phi_q;
	logic          half_q;
	logic          byte_acc;
	logic          calc_go;
	logic          take_d, rreq_d;
	logic [2:0]    cls;
	logic [4:0]    mode;

	assign byte_acc = BYTE_TAKE && BYTE_VALID;
	assign cls = BYTE_DATA[OPC_CLS_LSB +: 3];
	assign mode = BYTE_DATA[OPC_MODE_W-1:0];
	assign calc_go = (state_q == S_CALC);

	// Classify the opcode; long forms in RMW or bit classes are refused
	always_comb begin
		info_d = '0;
		info_d.mode = mode;
		info_d.len = mode_len(mode); // [RQ5] [RQ6] [RQ7] [RQ10]
		info_d.ptr_need = mode_ptr(mode); // [RQ8]
		info_d.ptr_word = mode_word(mode); // [RQ8]
		info_d.is_long = mode_long(mode); // [RQ2]
		info_d.illegal = (mode >= MODE_COUNT) // [RQ1]
			|| ((cls inside {CLS_RMW, CLS_BIT, CLS_BIT_BR})
			&& mode_long(mode)) // [RQ4]
			|| (cls == CLS_BIT
			&& !(mode inside {M_BIT_D, M_BIT_I})) // [RQ10]
			|| (cls == CLS_BIT_BR
			&& !(mode inside {M_BTB_D, M_BTB_I}))
			|| (cls == CLS_BRANCH
			&& !(mode inside {M_REL_D, M_REL_I})) // [RQ9]
			|| (cls > CLS_BRANCH);
	end

	// Sequencer next state
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			S_IDLE: if (byte_acc) state_d = S_INFO;
			S_INFO: begin
				// Info stands one cycle before any operand byte is taken
				if (DEC_INFO.illegal) // [RQ11]
					state_d = S_IDLE;
				else if (DEC_INFO.len != 2'd0)
					state_d = S_OPER;
				else
					state_d = S_CALC;
			end
			S_OPER: begin
				if (byte_acc && cnt_q == DEC_INFO.len - 2'd1)
					state_d = DEC_INFO.ptr_need ? S_PTR : S_CALC;
			end
			S_PTR: begin
				if (MEM_RVALID && (!DEC_INFO.ptr_word || half_q))
					state_d = S_CALC;
			end
			S_CALC: state_d = S_WAIT;
			S_WAIT: state_d = S_IDLE;
			default: state_d = S_IDLE;
		endcase
	end

	// Stream ready tracks the next state so no byte is over-taken
	assign take_d = (state_d == S_IDLE) || (state_d == S_OPER);

	// A pointer read is issued on entry and again for a word's low half
	assign rreq_d = (state_d == S_PTR) && ((state_q != S_PTR)
		|| (MEM_RVALID && DEC_INFO.ptr_word && !half_q));

	// State, handshake and request flops
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			state_q   <= S_IDLE;
			BYTE_TAKE <= 1'b0;
			MEM_RREQ  <= 1'b0;
		end else begin
			state_q   <= state_d;
			BYTE_TAKE <= take_d;
			MEM_RREQ  <= rreq_d; // [RQ8]
		end
	end

	// Mode information, latched from the opcode byte
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			DEC_INFO       <= '0;
			DEC_INFO_VALID <= 1'b0;
			DEC_ILLEGAL    <= 1'b0;
		end else begin
			if (state_q == S_IDLE && byte_acc)
				DEC_INFO <= info_d;
			if (state_q == S_IDLE && byte_acc)
				DEC_INFO_VALID <= 1'b1; // [RQ11]
			else if (state_d == S_IDLE)
				DEC_INFO_VALID <= 1'b0;
			DEC_ILLEGAL <= (state_q == S_INFO) && DEC_INFO.illegal; // [RQ4]
		end
	end

	// Operand bytes, stored in arrival order
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			cnt_q <= 2'd0;
			opb_q <= '{default: 8'h00};
		end else if (state_q == S_INFO) begin
			cnt_q <= 2'd0;
		end else if (state_q == S_OPER && byte_acc) begin
			opb_q[cnt_q] <= BYTE_DATA;
			cnt_q <= cnt_q + 2'd1;
		end
	end

	// Pointer fetch: word pointers give the high byte first
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			MEM_RADDR <= '0;
			plo_q     <= 8'h00;
			phi_q     <= 8'h00;
			half_q    <= 1'b0;
		end else begin
			if (rreq_d && state_q != S_PTR) begin
				MEM_RADDR <= page0(state_q == S_OPER && cnt_q == 2'd0
					? BYTE_DATA : opb_q[0]); // [RQ8]
				half_q <= 1'b0;
			end else if (rreq_d) begin
				MEM_RADDR <= page0(MEM_RADDR[7:0] + 8'h01);
			end
			if (state_q == S_PTR && MEM_RVALID) begin
				if (DEC_INFO.ptr_word && !half_q) begin
					phi_q  <= MEM_RDATA;
					half_q <= 1'b1;
				end else begin
					plo_q <= MEM_RDATA;
				end
			end
		end
	end

	// Address forming stage; its flops drive the result ports
	cpuamd_ea_calc u_calc (
		.clk    (SYS_CLK),
		.rst    (SYS_RST),
		.go     (calc_go),
		.mode   (DEC_INFO.mode),
		.b1     (opb_q[0]),
		.b2     (opb_q[1]),
		.b3     (opb_q[2]),
		.plo    (plo_q),
		.phi    (phi_q),
		.x      (INDEX_X),
		.pc     (PC_NEXT),
		.res_q  (DEC_RESULT),
		.done_q (DEC_DONE)
	);

	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (SYS_RST);

	sequence s_opc_taken;
		state_q == S_IDLE && byte_acc;
	endsequence
	sequence s_info_up;
		DEC_INFO_VALID && state_q == S_INFO;
	endsequence

	a_info_first: assert property (s_opc_taken |=> s_info_up ##1 // [RQ11]
		(!(DEC_INFO.len != 2'd0 && !DEC_INFO.illegal) || BYTE_TAKE))
		else $error("operand fetch before mode info");
	a_info_on_take: assert property (state_q == S_OPER && byte_acc // [RQ11]
		|-> DEC_INFO_VALID)
		else $error("operand taken without mode info");
	a_modes_range: assert property (DEC_INFO_VALID && // [RQ1]
		!DEC_INFO.illegal |-> DEC_INFO.mode < MODE_COUNT)
		else $error("mode code out of range");
	a_inh_imm_len: assert property (DEC_INFO_VALID |-> // [RQ5]
		(DEC_INFO.mode == M_INH -> DEC_INFO.len == 2'd0) &&
		(DEC_INFO.mode == M_IMM -> DEC_INFO.len == 2'd1))
		else $error("inherent or immediate length wrong");
	a_idx0_len: assert property (DEC_INFO_VALID && // [RQ6]
		DEC_INFO.mode == M_IDX_0 |-> DEC_INFO.len == 2'd0)
		else $error("no-offset indexed carries bytes");
	a_rmw_short: assert property (s_opc_taken and (cls == CLS_RMW // [RQ4]
		&& mode_long(mode)) |=> ##1 DEC_ILLEGAL)
		else $error("long form accepted for memory op");
	a_ind_ptr: assert property (DEC_INFO_VALID && // [RQ8]
		DEC_INFO.mode inside {M_IND_S, M_IND_L} |->
		DEC_INFO.ptr_need && DEC_INFO.len == 2'd2)
		else $error("indirect pointer or length wrong");
	a_btb_len: assert property (DEC_INFO_VALID && // [RQ10]
		DEC_INFO.mode == M_BTB_I |-> DEC_INFO.len == 2'd3)
		else $error("indirect bit branch length wrong");
	a_rel_reach: assert property (DEC_DONE && !DEC_RESULT.rel_bad // [RQ9]
		&& DEC_INFO.mode == M_REL_D |-> (DEC_RESULT.target
		- $past(PC_NEXT, 2)) + 16'h007F <= 16'h00FE)
		else $error("branch target out of reach");
	// The result flop loads on the S_CALC edge, so done shows one cycle on
	a_done_bound: assert property (state_q == S_CALC |=> DEC_DONE)
		else $error("result not delivered in time");

endmodule // cpuamd_decoder
`default_nettype wire

// file: logic/cpuamd_ea_calc.sv
// Effective address and branch target former, one registered stage.
// Assumes operand bytes, pointer bytes, index and next PC are stable
// while go is high.
`timescale 1ns/100ps
`default_nettype none
module cpuamd_ea_calc
	import cpuamd_pkg::*;
(
	input  wire logic           clk,
	input  wire logic           rst,
	input  wire logic           go,
	input  wire logic [4:0]     mode,
	input  wire logic [7:0]     b1,
	input  wire logic [7:0]     b2,
	input  wire logic [7:0]     b3,
	input  wire logic [7:0]     plo,
	input  wire logic [7:0]     phi,
	input  wire logic [7:0]     x,
	input  wire logic [15:0]    pc,
	output var  cpuamd_result_s res_q,
	output var  logic           done_q
);

	cpuamd_result_s res_d;
	logic [7:0]     ofs;

	// Short forms stay in page zero; indexed short reaches 01FE at most
	always_comb begin
		res_d = '0;
		ofs = b1;
		unique case (mode)
			M_IMM: begin
				res_d.imm = b1; // [RQ5]
				res_d.is_imm = 1'b1;
			end
			M_DIR_S, M_BIT_D, M_BTB_D: res_d.ea = page0(b1); // [RQ3] [RQ10]
			M_DIR_L: res_d.ea = {b1, b2}; // [RQ2]
			M_IDX_0: res_d.ea = page0(x); // [RQ6]
			M_IDX_S: res_d.ea = page0(b1) + page0(x); // [RQ7]
			M_IDX_L: res_d.ea = {b1, b2} + page0(x); // [RQ7]
			M_IND_S, M_BIT_I, M_BTB_I: res_d.ea = page0(plo); // [RQ8]
			M_IND_L: res_d.ea = {phi, plo}; // [RQ8]
			M_IIX_S: res_d.ea = page0(plo) + page0(x);
			M_IIX_L: res_d.ea = {phi, plo} + page0(x);
			default: res_d.ea = '0;
		endcase
		// Branch offset source differs per form
		unique case (mode)
			M_REL_I: ofs = plo;
			M_BTB_D: ofs = b2;
			M_BTB_I: ofs = b3;
			default: ofs = b1;
		endcase
		res_d.target = pc + {{8{ofs[7]}}, ofs}; // [RQ9]
		// -128 lies outside the documented reach, so it is flagged
		res_d.rel_bad = (mode inside {M_REL_D, M_REL_I, M_BTB_D,
			M_BTB_I}) && (ofs == REL_OFS_BAD); // [RQ9]
	end

	// Result register
	always_ff @(posedge clk) begin
		if (rst) begin
			res_q  <= '0;
			done_q <= 1'b0;
		end else begin
			done_q <= go;
			if (go)
				res_q <= res_d;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_short_page0: assert property (go && mode == M_DIR_S |=> // [RQ3]
		res_q.ea[15:8] == PAGE_ZERO_HI)
		else $error("short direct left page zero");
	a_idx_reach: assert property (go && mode == M_IDX_S |=> // [RQ7]
		res_q.ea <= IDX_SHORT_MAX)
		else $error("short indexed beyond 01FE");
	a_long_full: assert property (go && mode == M_DIR_L |=> // [RQ2]
		res_q.ea == {$past(b1), $past(b2)})
		else $error("long direct address wrong");

endmodule // cpuamd_ea_calc
`default_nettype wire

// file: logic/cpuamd_pkg.sv
// Package for the addressing mode decoder: mode codes, opcode fields,
// state codes, carrier structs and per-mode length and pointer tables.
// Assumes one 100 MHz clock and a synchronous active-high reset.
package cpuamd_pkg;

	// Opcode layout: class in the top three bits, mode in the low five
	localparam int OPC_CLS_LSB = 5;
	localparam int OPC_MODE_W  = 5;
	localparam logic [4:0] MODE_COUNT = 5'h11;

	// Operation classes
	localparam logic [2:0] CLS_GENERAL = 3'h0;
	localparam logic [2:0] CLS_RMW     = 3'h1;
	localparam logic [2:0] CLS_BIT     = 3'h2;
	localparam logic [2:0] CLS_BIT_BR  = 3'h3;
	localparam logic [2:0] CLS_BRANCH  = 3'h4;

	// Page zero upper address byte
	localparam logic [7:0] PAGE_ZERO_HI = 8'h00;
	localparam logic [15:0] IDX_SHORT_MAX = 16'h01FE;
	localparam logic [7:0] REL_OFS_BAD = 8'h80;

	typedef enum logic [4:0] {
		M_INH   = 5'b00000, M_IMM   = 5'b00001,
		M_DIR_S = 5'b00010, M_DIR_L = 5'b00011,
		M_IDX_0 = 5'b00100, M_IDX_S = 5'b00101,
		M_IDX_L = 5'b00110, M_IND_S = 5'b00111,
		M_IND_L = 5'b01000, M_IIX_S = 5'b01001,
		M_IIX_L = 5'b01010, M_REL_D = 5'b01011,
		M_REL_I = 5'b01100, M_BIT_D = 5'b01101,
		M_BIT_I = 5'b01110, M_BTB_D = 5'b01111,
		M_BTB_I = 5'b10000
	} cpuamd_mode_e;

	typedef enum logic [2:0] {
		S_IDLE = 3'b000, S_INFO = 3'b001, S_OPER = 3'b010,
		S_PTR  = 3'b011, S_CALC = 3'b100, S_WAIT = 3'b101
	} cpuamd_state_e;

	typedef struct packed {
		logic [4:0] mode;
		logic [1:0] len;
		logic       ptr_need;
		logic       ptr_word;
		logic       is_long;
		logic       illegal;
	} cpuamd_info_s;

	typedef struct packed {
		logic [15:0] ea;
		logic [15:0] target;
		logic [7:0]  imm;
		logic        is_imm;
		logic        rel_bad;
	} cpuamd_result_s;

	// Operand bytes after the opcode
	function automatic logic [1:0] mode_len(input logic [4:0] m);
		unique case (m)
			M_INH, M_IDX_0: return 2'd0;
			M_IMM, M_DIR_S, M_IDX_S, M_REL_D, M_BIT_D: return 2'd1;
			M_BTB_I: return 2'd3;
			default: return 2'd2;
		endcase
	endfunction

	function automatic logic mode_ptr(input logic [4:0] m);
		return m inside {M_IND_S, M_IND_L, M_IIX_S, M_IIX_L,
			M_REL_I, M_BIT_I, M_BTB_I};
	endfunction

	function automatic logic mode_word(input logic [4:0] m);
		return m inside {M_IND_L, M_IIX_L};
	endfunction

	function automatic logic mode_long(input logic [4:0] m);
		return m inside {M_DIR_L, M_IDX_L, M_IND_L, M_IIX_L};
	endfunction

	function automatic logic [15:0] page0(input logic [7:0] a);
		return {PAGE_ZERO_HI, a};
	endfunction

endpackage

// file: sim/cpuamd_decoder_test.sv
// Bench for the addressing mode decoder: all modes with edge and random
// operands, class pairings, refusals and a reset in mid-run.
// Assumes the memory model and the design share one 100 MHz clock.
`timescale 1ns/100ps
`default_nettype none
module cpuamd_decoder_test import cpuamd_pkg::*;;
	typedef struct packed {
		logic        ill, cea, ctg;
		logic [15:0] ea, tg;
		logic [7:0]  imm;
		logic        isi, rb;
	} cpuamd_exp_s;
	localparam logic [33:0] LENS = 34'h3_A66A_A494;
	localparam logic [10:0][8:0] TBL = {
		{1'b0, CLS_RMW, M_DIR_S}, {1'b0, CLS_BIT, M_BIT_D},
		{1'b0, CLS_BIT_BR, M_BTB_D}, {1'b0, CLS_BRANCH, M_REL_D},
		{1'b1, CLS_RMW, M_DIR_L}, {1'b1, CLS_RMW, M_IDX_L},
		{1'b1, CLS_RMW, M_IND_L}, {1'b1, CLS_RMW, M_IIX_L},
		{1'b1, CLS_BIT, M_DIR_L}, {1'b1, 3'h0, 5'h11}, {1'b1, 3'h5, 5'h00}};
	logic           SYS_CLK    = 1'b0;
	logic           SYS_RST    = 1'b1;
	logic           BYTE_VALID = 1'b0;
	logic           slow       = 1'b0;
	logic [7:0]     BYTE_DATA  = 8'h00;
	logic [7:0]     INDEX_X    = 8'h00;
	logic [15:0]    PC_NEXT    = 16'h0000;
	logic [7:0]     MEM_RDATA;
	logic [15:0]    MEM_RADDR;
	logic           BYTE_TAKE, MEM_RREQ, MEM_RVALID;
	logic           DEC_INFO_VALID, DEC_ILLEGAL, DEC_DONE;
	cpuamd_info_s   DEC_INFO;
	cpuamd_result_s DEC_RESULT;
	cpuamd_exp_s    exp_q [$];
	cpuamd_exp_s    cur;
	int             fail_count = 0;
	int             num_checks = 0;
	logic [31:0]    seed = 32'he500;

	// Clock of 10 ns
	initial begin
		forever #5 SYS_CLK = ~SYS_CLK;
	end

	cpuamd_decoder dut (.SYS_CLK, .SYS_RST, .BYTE_VALID, .BYTE_DATA,
		.BYTE_TAKE, .INDEX_X, .PC_NEXT, .MEM_RREQ, .MEM_RADDR, .MEM_RVALID,
		.MEM_RDATA, .DEC_INFO, .DEC_INFO_VALID, .DEC_ILLEGAL, .DEC_RESULT,
		.DEC_DONE);
	cpuamd_mem_model mem (.SYS_CLK, .SYS_RST, .slow, .MEM_RREQ, .MEM_RADDR,
		.MEM_RVALID, .MEM_RDATA);

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic tally_and_finish();
		$display("checks %0d, mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic check(input logic ok, input string msg);
		num_checks++;
		if (!ok) begin
			fail_count++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask

	// Expected outcome; pointers read the model's scrambled page zero
	function automatic cpuamd_exp_s expect_of(input logic [4:0] m,
		input logic [23:0] b, input logic [7:0] x, input logic [15:0] pc);
		cpuamd_exp_s e;
		logic [15:0] p, w;
		logic [7:0] o;
		e = '0;
		p = {8'h00, b[23:16] ^ 8'h5A};
		w = {b[23:16] ^ 8'h5A, (b[23:16] + 8'h01) ^ 8'h5A};
		e.cea = !(m inside {M_INH, M_REL_D, M_REL_I});
		e.ctg = m inside {M_REL_D, M_REL_I, M_BTB_D, M_BTB_I};
		e.isi = m == M_IMM;
		e.imm = b[23:16];
		case (m)
			M_DIR_S, M_BIT_D, M_BTB_D: e.ea = {8'h00, b[23:16]};
			M_DIR_L: e.ea = b[23:8];
			M_IDX_0: e.ea = {8'h00, x};
			M_IDX_S: e.ea = {8'h00, b[23:16]} + x;
			M_IDX_L: e.ea = b[23:8] + x;
			M_IND_S, M_BIT_I, M_BTB_I: e.ea = p;
			M_IIX_S: e.ea = p + x;
			M_IND_L: e.ea = w;
			M_IIX_L: e.ea = w + x;
			default: e.ea = 16'h0000;
		endcase
		o = m == M_REL_D ? b[23:16] : m == M_REL_I ? p[7:0] :
			m == M_BTB_D ? b[15:8] : b[7:0];
		e.tg = pc + {{8{o[7]}}, o};
		e.rb = o == 8'h80;
		return e;
	endfunction

	// Offers one byte and returns at the falling edge after it is taken
	task automatic put_byte(input logic [7:0] d);
		int i;
		BYTE_VALID = 1'b1;
		BYTE_DATA  = d;
		for (i = 0; i < 40 && BYTE_TAKE !== 1'b1; i++)
			@(negedge SYS_CLK);
		if (i == 40) begin
			check(1'b0, "byte never taken");
			tally_and_finish();
		end
		@(negedge SYS_CLK);
	endtask

	task automatic run_instr(input logic [7:0] op, input logic [23:0] b,
		input logic bad);
		cpuamd_exp_s e;
		logic [4:0] m;
		int i;
		m = op[4:0];
		e = expect_of(m, b, INDEX_X, PC_NEXT);
		e.ill = bad;
		exp_q.push_back(e);
		put_byte(op);
		check(DEC_INFO_VALID === 1'b1 && BYTE_TAKE === 1'b0
			&& DEC_INFO.illegal === bad, "info");
		if (!bad) begin
			check(DEC_INFO.mode === m && DEC_INFO.len === LENS[2*m +: 2],
				"mode or length");
			check(DEC_INFO.ptr_need === (m inside {7, 8, 9, 10, 12, 14, 16})
				&& DEC_INFO.is_long === (m inside {3, 6, 8, 10})
				&& DEC_INFO.ptr_word === (m inside {8, 10}),
				"pointer or reach");
			for (i = 0; i < LENS[2*m +: 2]; i++)
				put_byte(b[23-8*i -: 8]);
		end
		BYTE_VALID = 1'b0;
		BYTE_DATA  = ~BYTE_DATA;
		for (i = 0; i < 40 && DEC_DONE !== 1'b1 && DEC_ILLEGAL !== 1'b1; i++)
			@(negedge SYS_CLK);
		if (i == 40) begin
			check(1'b0, "no completion");
			tally_and_finish();
		end
		@(negedge SYS_CLK);
	endtask

	// Each completion or refusal retires the oldest expectation
	always @(negedge SYS_CLK) begin
		if (DEC_DONE === 1'b1 || DEC_ILLEGAL === 1'b1) begin
			if (exp_q.size() == 0) begin
				check(1'b0, "unexpected result");
			end else begin
				cur = exp_q.pop_front();
				check(DEC_ILLEGAL === cur.ill, "refusal");
				if (!cur.ill) begin
					check(!cur.cea || DEC_RESULT.ea === cur.ea, "address");
					check(DEC_RESULT.is_imm === cur.isi && (!cur.isi ||
						DEC_RESULT.imm === cur.imm), "immediate");
					check(!cur.ctg || {DEC_RESULT.target, DEC_RESULT.rel_bad}
						=== {cur.tg, cur.rb}, "target");
				end
			end
		end
	end

	// Main sequence: modes per pass, class table, reset in mid-run
	initial begin
		logic [31:0] r, q;
		logic [23:0] b;
		repeat (8) @(negedge SYS_CLK);
		check(BYTE_TAKE === 1'b0 && DEC_INFO === '0, "reset state");
		SYS_RST = 1'b0;
		for (int pass = 0; pass < 6; pass++) begin
			slow = pass[0];
			for (int m = 0; m < 17; m++) begin
				r = xs();
				q = xs();
				b = pass == 0 ? 24'hFF_FFFF :
					pass == 1 ? 24'h80_8080 : q[23:0];
				INDEX_X = pass == 0 ? 8'hFF : r[7:0];
				PC_NEXT = r[31:16];
				run_instr({3'h0, m[4:0]}, b, 1'b0);
			end
			$display("mode pass %0d done", pass);
		end
		for (int k = 0; k < 11; k++) begin
			r = xs();
			run_instr(TBL[k][7:0], r[23:0], TBL[k][8]);
		end
		$display("class table done");
		SYS_RST = 1'b1;
		repeat (2) @(negedge SYS_CLK);
		check(DEC_INFO_VALID === 1'b0 && MEM_RREQ === 1'b0, "mid reset");
		SYS_RST = 1'b0;
		run_instr({3'h0, M_IIX_L}, 24'hFF_0000, 1'b0);
		$display("reset test done");
		check(exp_q.size() == 0, "result missing");
		tally_and_finish();
	end
endmodule // cpuamd_decoder_test
`default_nettype wire

// file: sim/cpuamd_mem_model.sv
// Page-zero data memory model that answers the decoder's pointer reads.
// Assumes one read outstanding at a time, as the decoder issues them.
`timescale 1ns/100ps
`default_nettype none
module cpuamd_mem_model (
	input  wire logic        SYS_CLK,
	input  wire logic        SYS_RST,
	input  wire logic        slow,
	input  wire logic        MEM_RREQ,
	input  wire logic [15:0] MEM_RADDR,
	output var  logic        MEM_RVALID,
	output var  logic [7:0]  MEM_RDATA
);
	logic [1:0] wait_q;
	logic [7:0] addr_q;

	// Content is a scramble of the address; idle data toggles every
	// cycle so that a late sample never matches by luck
	always_ff @(posedge SYS_CLK) begin
		MEM_RVALID <= 1'b0;
		MEM_RDATA  <= ~MEM_RDATA;
		if (SYS_RST) begin
			wait_q    <= 2'h0;
			MEM_RDATA <= 8'hA5;
		end else if (MEM_RREQ && !slow) begin
			MEM_RVALID <= 1'b1;
			MEM_RDATA  <= MEM_RADDR[7:0] ^ 8'h5A;
		end else if (MEM_RREQ) begin
			addr_q <= MEM_RADDR[7:0];
			wait_q <= 2'h3;
		end else if (wait_q == 2'h1) begin
			MEM_RVALID <= 1'b1;
			MEM_RDATA  <= addr_q ^ 8'h5A;
			wait_q     <= 2'h0;
		end else if (wait_q != 2'h0) begin
			wait_q <= wait_q - 2'h1;
		end
	end
endmodule // cpuamd_mem_model
`default_nettype wire
